// >>> hw/ccd_decoder.sv
// Purpose: Decodes transfer, erase, protection and lock commands of a serial flash card.
// Assumes: The data path moves the data and reports blocks and completion.
// Notes: Outputs are registered; link inputs are synchronised here.
// How it works
// - Index 16 stores the argument as block length; normal response.
// - Before index 16 the card data default block length applies.
// - Index 17 starts one block read of current length at argument address.
// - Index 18 reads consecutive blocks until stop arrives.
// - Block read crossing boundary flagged unless read misalignment allowed.
// - Index 20 starts stream write at argument address until stop.
// - Index 23 count in bits 15..0, upper zero, for next multiple transfer.
// - Index 24 receives and programs one block at argument address.
// - Index 25 receives blocks until stop arrives.
// - Block write crossing boundary flagged unless write misalignment allowed.
// - Index 26 programs identity register once; later attempts blocked.
// - Index 27 updates only programmable card data bits.
// - Index 32 records first tagged sector.
// - Index 33 records last sector of range or single sector.
// - Indices 35 and 36 record first and last erase group.
// - Indices 34 and 37 remove a sector or group from selection.
// - Index 38 erases tagged sectors, busy until done.
// - Index 28 protects the group holding the address, then busy.
// - Index 29 unprotects the addressed group, busy until done.
// - Index 30 sends protection bits followed by 16-bit checksum.
// - Last payload bit belongs to first addressed group.
// - Index 42 receives a lock data block of block length, then busy.
// - Frames have start 0, direction 1, index, argument, checksum, end bit.
// - Index 12 stops open transfers and returns to ready.
// - Busy responses to indices 28, 29 and 38 hold data line low until operation done; the busy response to index 12 does not.
`timescale 1ns/1ps
`include "ccd_params.svh"
module ccd_decoder
  import ccd_pkg::*;
#(
  parameter int NGRP = 32,
  parameter int NUNTAG = 4
) (
  // Clock, reset and enable.
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  // Link pins from the host.
  input wire logic sclk_i,
  input wire logic cmd_i,
  // Busy drive on the data line, open drain.
  output logic dat0_o,
  output logic dat0_oe_n_o,
  // Card data fields.
  input wire logic [31:0] csd_blklen_dflt_i,
  input wire logic [31:0] phys_blk_bytes_i,
  input wire logic read_misalignment_flag_i,
  input wire logic write_misalignment_flag_i,
  input wire logic [31:0] protection_group_size_field_i,
  // Data path handshake.
  input wire logic blk_done_i,
  input wire logic op_done_i,
  input wire logic [127:0] rx_block_i,
  input wire logic [127:0] csd_prog_mask_i,
  // Command results.
  output logic resp_vld_o,
  output logic resp_busy_o,
  output logic [5:0] resp_idx_o,
  output logic resp_err_o,
  output ccd_xfer_e xfer_o,
  output logic [31:0] xfer_addr_o,
  output logic [31:0] blk_len_o,
  output logic [15:0] blk_cnt_o,
  output logic blk_cnt_act_o,
  output logic [127:0] card_identity_register_o,
  output logic card_identity_locked_o,
  output logic [127:0] card_specific_data_register_o,
  // Erase selection.
  output logic [31:0] sec_first_o,
  output logic [31:0] sec_last_o,
  output logic [31:0] grp_first_o,
  output logic [31:0] grp_last_o,
  output logic sel_sec_o,
  output logic sel_grp_o,
  output logic [31:0] untag_sec_o,
  output logic [31:0] untag_grp_o,
  output logic erase_go_o,
  // Protection.
  output logic [NGRP-1:0] wp_bits_o,
  output logic [NGRP+`CCD_WP_CRC_BITS-1:0] wp_payload_o
);
  //////////////////////////////////////////////////////////////////////////////
  logic [1:0] sync_q;
  logic sclk_prev_q;
  logic sclk_rise;
  logic f_vld;
  logic [5:0] f_idx;
  logic [31:0] f_arg;

  ccd_sync #(.W(2)) u_sync (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .en_i(ce_i),
    .d_i({sclk_i, cmd_i}),
    .q_o(sync_q)
  );

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sclk_prev_q <= 1'b0;
    end else if (ce_i) begin
      sclk_prev_q <= sync_q[1];
    end
  end
  assign sclk_rise = sync_q[1] & ~sclk_prev_q;

  ccd_frame_rx u_rx (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .en_i(ce_i),
    .sclk_rise_i(sclk_rise),
    .cmd_i(sync_q[0]),
    .frame_vld_o(f_vld),
    .frame_idx_o(f_idx),
    .frame_arg_o(f_arg)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Group number of an address; group size in bytes comes from the card data.
  function automatic logic [31:0] grp_of(input logic [31:0] a, input logic [31:0] sz);
    grp_of = (sz == 32'h0) ? a : a / sz;
  endfunction

  function automatic logic crosses(input logic [31:0] a, input logic [31:0] len,
                                   input logic [31:0] pb);
    crosses = (pb != 32'h0) && (len != 32'h0) && ((a % pb) + len > pb);
  endfunction

  logic blklen_set_q;
  logic [31:0] blklen_q;
  logic [31:0] cur_len;
  logic [15:0] cnt_left_q;
  logic cnt_armed_q;
  logic busy_q;
  logic is_multi;
  logic single_q;
  logic [31:0] wp_idx;

  assign cur_len = blklen_set_q ? blklen_q : csd_blklen_dflt_i;
  assign is_multi = (xfer_o == CCD_XF_RD || xfer_o == CCD_XF_WR);
  assign wp_idx = grp_of(f_arg, protection_group_size_field_i);

  //////////////////////////////////////////////////////////////////////////////
  // Response and transfer state.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      resp_vld_o <= 1'b0;
      resp_busy_o <= 1'b0;
      resp_idx_o <= '0;
      resp_err_o <= 1'b0;
      xfer_o <= CCD_XF_NONE;
      xfer_addr_o <= '0;
      blklen_set_q <= 1'b0;
      blklen_q <= '0;
      blk_len_o <= '0;
      busy_q <= 1'b0;
    end else if (ce_i) begin
      resp_vld_o <= 1'b0;
      blk_len_o <= cur_len;
      if (busy_q && op_done_i) begin
        busy_q <= 1'b0;
      end
      if (blk_done_i && is_multi && cnt_armed_q && cnt_left_q == 16'h1) begin
        xfer_o <= CCD_XF_NONE;
      end else if (blk_done_i && (single_q || !is_multi) && xfer_o != CCD_XF_STREAM) begin
        xfer_o <= CCD_XF_NONE;
        if (xfer_o == CCD_XF_LOCK || xfer_o == CCD_XF_PROG_ID ||
            xfer_o == CCD_XF_PROG_CSD) begin
          busy_q <= 1'b1;
        end
      end
      if (f_vld) begin
        resp_vld_o <= 1'b1;
        resp_idx_o <= f_idx;
        resp_busy_o <= `CCD_RESP_NORMAL;
        resp_err_o <= 1'b0;
        xfer_addr_o <= f_arg;
        unique case (f_idx)
          `CCD_IDX_STOP: begin
            xfer_o <= CCD_XF_NONE;
            resp_busy_o <= `CCD_RESP_BUSY;
          end
          `CCD_IDX_BLKLEN: begin
            blklen_q <= f_arg;
            blklen_set_q <= 1'b1;
          end
          `CCD_IDX_RD_ONE, `CCD_IDX_RD_MUL: begin
            xfer_o <= CCD_XF_RD;
            resp_err_o <= !read_misalignment_flag_i &&
                          crosses(f_arg, cur_len, phys_blk_bytes_i);
          end
          `CCD_IDX_STREAM_WR: xfer_o <= CCD_XF_STREAM;
          `CCD_IDX_BLKCNT: resp_err_o <= (f_arg[31:16] != 16'h0);
          `CCD_IDX_WR_ONE, `CCD_IDX_WR_MUL: begin
            xfer_o <= CCD_XF_WR;
            resp_err_o <= !write_misalignment_flag_i &&
                          crosses(f_arg, cur_len, phys_blk_bytes_i);
          end
          `CCD_IDX_PROG_ID: begin
            if (card_identity_locked_o) begin
              resp_err_o <= 1'b1;
            end else begin
              xfer_o <= CCD_XF_PROG_ID;
            end
          end
          `CCD_IDX_PROG_CSD: xfer_o <= CCD_XF_PROG_CSD;
          `CCD_IDX_PROT_SET, `CCD_IDX_PROT_CLR, `CCD_IDX_ERASE: begin
            resp_busy_o <= `CCD_RESP_BUSY;
            busy_q <= 1'b1;
          end
          `CCD_IDX_PROT_STAT: xfer_o <= CCD_XF_WP_STAT;
          `CCD_IDX_LOCK: xfer_o <= CCD_XF_LOCK;
          default: ;
        endcase
      end
    end
  end

  // Single-block kinds finish on the first block; multi ones only on stop or count.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      single_q <= 1'b0;
    end else if (ce_i && f_vld) begin
      single_q <= (f_idx == `CCD_IDX_RD_ONE || f_idx == `CCD_IDX_WR_ONE);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Block count, valid for the very next multiple transfer only.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_left_q <= '0;
      cnt_armed_q <= 1'b0;
      blk_cnt_o <= '0;
      blk_cnt_act_o <= 1'b0;
    end else if (ce_i) begin
      if (f_vld) begin
        if (f_idx == `CCD_IDX_BLKCNT) begin
          cnt_left_q <= f_arg[15:0];
          blk_cnt_o <= f_arg[15:0];
        end else if (f_idx == `CCD_IDX_RD_MUL || f_idx == `CCD_IDX_WR_MUL) begin
          cnt_armed_q <= (blk_cnt_o != 16'h0);
          blk_cnt_act_o <= (blk_cnt_o != 16'h0);
          blk_cnt_o <= '0;
        end else if (f_idx == `CCD_IDX_STOP) begin
          cnt_armed_q <= 1'b0;
          blk_cnt_act_o <= 1'b0;
        end
      end else if (blk_done_i && cnt_armed_q) begin
        cnt_left_q <= cnt_left_q - 16'h1;
        if (cnt_left_q == 16'h1) begin
          cnt_armed_q <= 1'b0;
          blk_cnt_act_o <= 1'b0;
        end
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Identity and card data programming.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      card_identity_register_o <= '0;
      card_identity_locked_o <= 1'b0;
      card_specific_data_register_o <= '0;
    end else if (ce_i && blk_done_i) begin
      if (xfer_o == CCD_XF_PROG_ID && !card_identity_locked_o) begin
        card_identity_register_o <= rx_block_i;
        card_identity_locked_o <= 1'b1;
      end
      if (xfer_o == CCD_XF_PROG_CSD) begin
        card_specific_data_register_o <= (rx_block_i & csd_prog_mask_i) |
            (card_specific_data_register_o & ~csd_prog_mask_i);
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Erase selection; select flags cleared once an erase has completed.
  logic erase_run_q;
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sec_first_o <= '0;
      sec_last_o <= '0;
      grp_first_o <= '0;
      grp_last_o <= '0;
      sel_sec_o <= 1'b0;
      sel_grp_o <= 1'b0;
      untag_sec_o <= '0;
      untag_grp_o <= '0;
      erase_go_o <= 1'b0;
      erase_run_q <= 1'b0;
    end else if (ce_i) begin
      erase_go_o <= 1'b0;
      if (erase_run_q && op_done_i) begin
        erase_run_q <= 1'b0;
        sel_sec_o <= 1'b0;
        sel_grp_o <= 1'b0;
      end
      if (f_vld) begin
        unique case (f_idx)
          `CCD_IDX_SEC_START: begin
            sec_first_o <= f_arg;
            sec_last_o <= f_arg;
          end
          `CCD_IDX_SEC_END: begin
            sec_last_o <= f_arg;
            sel_sec_o <= 1'b1;
          end
          `CCD_IDX_SEC_UNTAG: untag_sec_o <= f_arg;
          `CCD_IDX_GRP_START: grp_first_o <= f_arg;
          `CCD_IDX_GRP_END: begin
            grp_last_o <= f_arg;
            sel_grp_o <= 1'b1;
          end
          `CCD_IDX_GRP_UNTAG: untag_grp_o <= f_arg;
          `CCD_IDX_ERASE: begin
            erase_go_o <= 1'b1;
            erase_run_q <= 1'b1;
          end
          default: ;
        endcase
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Group protection bits and the status payload.
  logic [NGRP-1:0] wp_q;
  logic [NGRP-1:0] wp_rev;
  assign wp_bits_o = wp_q;
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wp_q <= '0;
    end else if (ce_i && f_vld && wp_idx < NGRP) begin
      if (f_idx == `CCD_IDX_PROT_SET) begin
        wp_q[wp_idx[$clog2(NGRP)-1:0]] <= 1'b1;
      end else if (f_idx == `CCD_IDX_PROT_CLR) begin
        wp_q[wp_idx[$clog2(NGRP)-1:0]] <= 1'b0;
      end
    end
  end

  // Payload bit k holds group (start + k); bit 0, sent last, is the first group.
  genvar g;
  for (g = 0; g < NGRP; g++) begin : g_wp
    logic [31:0] gi;
    assign gi = wp_idx + 32'(g);
    assign wp_rev[g] = (gi < NGRP) ? wp_q[gi[$clog2(NGRP)-1:0]] : 1'b0;
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wp_payload_o <= '0;
    end else if (ce_i && f_vld && f_idx == `CCD_IDX_PROT_STAT) begin
      // Checksum slot is filled by the CRC block on the data path.
      wp_payload_o <= {wp_rev, {`CCD_WP_CRC_BITS{1'b0}}};
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Busy drive: hold the data line low while an internal operation runs.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      dat0_o <= 1'b1;
      dat0_oe_n_o <= 1'b1;
    end else if (ce_i) begin
      dat0_o <= 1'b0;
      dat0_oe_n_o <= !busy_q;
    end
  end
endmodule

// >>> hw/ccd_frame_rx.sv
// Purpose: Shifts command frames in on link clock rising edges.
// Assumes: Line and link clock are already synchronised.
// Notes: A frame is framed by its own start bit; idle line is high.
`timescale 1ns/1ps
`include "ccd_params.svh"
module ccd_frame_rx (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic en_i,
  // Link samples.
  input wire logic sclk_rise_i,
  input wire logic cmd_i,
  // Frame out.
  output logic frame_vld_o,
  output logic [5:0] frame_idx_o,
  output logic [31:0] frame_arg_o
);
  logic [47:0] shift_q;
  logic [5:0] cnt_q;
  logic busy_q;
  logic [47:0] nxt;
  assign nxt = {shift_q[46:0], cmd_i};
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      shift_q <= '0;
      cnt_q <= '0;
      busy_q <= 1'b0;
      frame_vld_o <= 1'b0;
      frame_idx_o <= '0;
      frame_arg_o <= '0;
    end else if (en_i) begin
      frame_vld_o <= 1'b0;
      if (sclk_rise_i) begin
        if (!busy_q) begin
          if (cmd_i == `CCD_START_VAL) begin
            busy_q <= 1'b1;
            cnt_q <= 6'h01;
            shift_q <= nxt;
          end
        end else begin
          shift_q <= nxt;
          cnt_q <= cnt_q + 6'h01;
          if (cnt_q == 6'(`CCD_FRAME_BITS - 1)) begin
            busy_q <= 1'b0;
            // Start, direction and end bits checked; checksum left to the CRC block.
            if (nxt[47] == `CCD_START_VAL && nxt[46] == `CCD_DIR_VAL &&
                nxt[0] == `CCD_END_VAL) begin
              frame_vld_o <= 1'b1;
              frame_idx_o <= nxt[45:40];
              frame_arg_o <= nxt[39:8];
            end
          end
        end
      end
    end
  end
endmodule

// >>> hw/ccd_params.svh
// Purpose: Constants for the card command decoder.
// Assumes: Included by bare name.
// Notes: Timing counts are in system clock cycles.
`ifndef CCD_PARAMS_SVH
`define CCD_PARAMS_SVH
`define CCD_FRAME_BITS 48
`define CCD_START_VAL 1'h0
`define CCD_DIR_VAL 1'h1
`define CCD_END_VAL 1'h1
`define CCD_IDX_STOP 6'h0c
`define CCD_IDX_BLKLEN 6'h10
`define CCD_IDX_RD_ONE 6'h11
`define CCD_IDX_RD_MUL 6'h12
`define CCD_IDX_STREAM_WR 6'h14
`define CCD_IDX_BLKCNT 6'h17
`define CCD_IDX_WR_ONE 6'h18
`define CCD_IDX_WR_MUL 6'h19
`define CCD_IDX_PROG_ID 6'h1a
`define CCD_IDX_PROG_CSD 6'h1b
`define CCD_IDX_PROT_SET 6'h1c
`define CCD_IDX_PROT_CLR 6'h1d
`define CCD_IDX_PROT_STAT 6'h1e
`define CCD_IDX_SEC_START 6'h20
`define CCD_IDX_SEC_END 6'h21
`define CCD_IDX_SEC_UNTAG 6'h22
`define CCD_IDX_GRP_START 6'h23
`define CCD_IDX_GRP_END 6'h24
`define CCD_IDX_GRP_UNTAG 6'h25
`define CCD_IDX_ERASE 6'h26
`define CCD_IDX_LOCK 6'h2a
`define CCD_WP_CRC_BITS 16
`define CCD_RESP_NORMAL 1'h0
`define CCD_RESP_BUSY 1'h1
`endif

// >>> hw/ccd_pkg.sv
// Purpose: Types shared by the card command decoder and its checks.
// Assumes: Compiled before every file that imports it.
// Notes: Transfer kinds carry no fixed codes.
package ccd_pkg;
  typedef enum logic [2:0] {
    CCD_XF_NONE,
    CCD_XF_RD,
    CCD_XF_WR,
    CCD_XF_STREAM,
    CCD_XF_PROG_ID,
    CCD_XF_PROG_CSD,
    CCD_XF_WP_STAT,
    CCD_XF_LOCK
  } ccd_xfer_e;
endpackage

// >>> hw/ccd_sync.sv
// Purpose: Two-flop synchroniser for a bundle of asynchronous levels.
// Assumes: Inputs come from outside the clk_i domain.
// Notes: The first stage feeds only the second stage.
`timescale 1ns/1ps
module ccd_sync #(
  parameter int W = 2
) (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic en_i,
  // Levels.
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  logic [W-1:0] meta_q;
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta_q <= '0;
      q_o <= '0;
    end else if (en_i) begin
      meta_q <= d_i;
      q_o <= meta_q;
    end
  end
endmodule

// >>> tb/ccd_decoder_assertions.sv
// Purpose: Concurrent checks on the card command decoder ports.
// Assumes: One clock domain, asynchronous active low reset.
// Notes: The bench holds csd_prog_mask_i steady while card data is programmed.
`timescale 1ns/1ps
`include "ccd_params.svh"
module ccd_decoder_assertions
  import ccd_pkg::*;
#(
  parameter int NGRP = 32
) (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Watched inputs.
  input wire logic op_done_i,
  input wire logic [127:0] csd_prog_mask_i,
  // Watched outputs.
  input wire logic dat0_o,
  input wire logic dat0_oe_n_o,
  input wire logic resp_vld_o,
  input wire logic resp_busy_o,
  input wire logic [5:0] resp_idx_o,
  input wire ccd_xfer_e xfer_o,
  input wire logic [127:0] card_identity_register_o,
  input wire logic card_identity_locked_o,
  input wire logic [127:0] card_specific_data_register_o,
  input wire logic [NGRP+15:0] wp_payload_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  a_busy_pulls_low: assert property (!dat0_oe_n_o |-> !dat0_o)
    else $error("data line enabled but not low");
  a_busy_kind_resp: assert property (
    resp_vld_o && resp_idx_o inside {`CCD_IDX_PROT_SET, `CCD_IDX_PROT_CLR, `CCD_IDX_ERASE}
    |-> resp_busy_o)
    else $error("busy type response missing");
  a_erase_busy_start: assert property (
    resp_vld_o && resp_idx_o == `CCD_IDX_ERASE |-> ##[1:2] !dat0_oe_n_o)
    else $error("erase did not drive busy");
  // The drive pin trails the busy flag by one cycle, so the cycle after completion is exempt.
  a_busy_holds_on: assert property (
    !dat0_oe_n_o && !op_done_i && !$past(op_done_i) |=> !dat0_oe_n_o)
    else $error("busy dropped before completion");
  a_busy_ends_done: assert property (!dat0_oe_n_o && op_done_i |-> ##[1:2] dat0_oe_n_o)
    else $error("busy held after completion");
  a_length_normal: assert property (
    resp_vld_o && resp_idx_o == `CCD_IDX_BLKLEN |-> !resp_busy_o)
    else $error("block length answer not normal");
  a_stop_to_idle: assert property (
    resp_vld_o && resp_idx_o == `CCD_IDX_STOP |-> ##[0:1] xfer_o == CCD_XF_NONE)
    else $error("stop left a transfer open");
  a_read_one_go: assert property (
    resp_vld_o && resp_idx_o == `CCD_IDX_RD_ONE |-> ##[0:1] xfer_o == CCD_XF_RD)
    else $error("single read not started");
  a_identity_frozen: assert property (
    card_identity_locked_o |=> card_identity_locked_o && $stable(card_identity_register_o))
    else $error("identity changed after lock");
  a_card_data_mask: assert property (
    1'b1 |=> ((card_specific_data_register_o ^ $past(card_specific_data_register_o))
    & ~csd_prog_mask_i) == '0)
    else $error("fixed card data bit changed");
  a_status_crc_zero: assert property (
    xfer_o == CCD_XF_WP_STAT |-> wp_payload_o[15:0] == 16'h0000)
    else $error("status checksum field not clear");
endmodule
bind ccd_decoder ccd_decoder_assertions #(.NGRP(NGRP)) u_chk (.clk_i, .rst_n_i, .op_done_i,
  .csd_prog_mask_i, .dat0_o, .dat0_oe_n_o, .resp_vld_o, .resp_busy_o, .resp_idx_o, .xfer_o,
  .card_identity_register_o, .card_identity_locked_o, .card_specific_data_register_o,
  .wp_payload_o);

// >>> tb/ccd_host_model.sv
// Purpose: Host side of the command line, sending framed commands.
// Assumes: The card samples the line on link clock rising edges.
// Notes: The link clock stands still low between frames.
`timescale 1ns/1ps
module ccd_host_model #(
  parameter int HALF = 40
) (
  // Link pins toward the card.
  output logic sclk_o,
  output logic cmd_o
);
  // The line rests high on its pull-up, so an idle line never looks like a start bit.
  initial begin
    sclk_o = 1'b0;
    cmd_o = 1'b1;
  end
  function automatic logic [6:0] crc7(input logic [39:0] d);
    logic [6:0] c;
    c = 7'h00;
    for (int i = 39; i >= 0; i--) begin
      c = {c[5:0], 1'b0} ^ ((d[i] ^ c[6]) ? 7'h09 : 7'h00);
    end
    return c;
  endfunction
  task automatic send(input logic [5:0] idx, input logic [31:0] arg, input logic bad);
    logic [47:0] f;
    f = {1'b0, ~bad, idx, arg, crc7({1'b0, ~bad, idx, arg}), 1'b1};
    for (int i = 47; i >= 0; i--) begin
      cmd_o = f[i];
      #(HALF) sclk_o = 1'b1;
      #(HALF) sclk_o = 1'b0;
    end
  endtask
endmodule

// >>> tb/tb_top.sv
// Purpose: Self-checking bench for the card command decoder.
// Assumes: Host model frames commands; bench plays the data path.
// Notes: Seeded random addresses, lengths and data with fixed corner cases.
`timescale 1ns/1ps
`include "ccd_params.svh"
module tb_top;
  import ccd_pkg::*;
  logic clk_i = 0, rst_n_i = 0, ce_i = 1, rflag = 0, wflag = 0, blk_done = 0, op_done = 0;
  logic [31:0] dflt = 32'h0, phys = 32'h200, gsz = 32'h1000, a, len, v, g;
  logic [127:0] rxb = '0, mask = '0, csd_m = '0, idm;
  logic [15:0] cnt;
  wire sclk_w, cmd_w;
  logic dat0_o, dat0_oe_n_o, resp_vld_o, resp_busy_o, resp_err_o, blk_cnt_act_o;
  logic card_identity_locked_o, sel_sec_o, sel_grp_o, erase_go_o, r_busy, r_err;
  logic [5:0] resp_idx_o, r_idx;
  ccd_xfer_e xfer_o;
  logic [31:0] xfer_addr_o, blk_len_o, sec_first_o, sec_last_o, grp_first_o, grp_last_o;
  logic [31:0] untag_sec_o, untag_grp_o, wp_bits_o;
  logic [15:0] blk_cnt_o;
  logic [127:0] card_identity_register_o, card_specific_data_register_o;
  logic [47:0] wp_payload_o;
  int mismatches = 0, comparisons = 0, nresp = 0, n_erase = 0, n;
  always #2.5 clk_i = ~clk_i;
  ccd_host_model host (.sclk_o(sclk_w), .cmd_o(cmd_w));
  ccd_decoder uut (.clk_i, .rst_n_i, .ce_i, .sclk_i(sclk_w), .cmd_i(cmd_w), .dat0_o,
    .dat0_oe_n_o, .csd_blklen_dflt_i(dflt), .phys_blk_bytes_i(phys),
    .read_misalignment_flag_i(rflag), .write_misalignment_flag_i(wflag),
    .protection_group_size_field_i(gsz), .blk_done_i(blk_done), .op_done_i(op_done),
    .rx_block_i(rxb), .csd_prog_mask_i(mask), .resp_vld_o, .resp_busy_o, .resp_idx_o,
    .resp_err_o, .xfer_o, .xfer_addr_o, .blk_len_o, .blk_cnt_o, .blk_cnt_act_o,
    .card_identity_register_o, .card_identity_locked_o, .card_specific_data_register_o,
    .sec_first_o, .sec_last_o, .grp_first_o, .grp_last_o, .sel_sec_o, .sel_grp_o,
    .untag_sec_o, .untag_grp_o, .erase_go_o, .wp_bits_o, .wp_payload_o);
  // Responses last one cycle, so they are latched here for the procedures.
  always @(posedge clk_i) begin
    if (resp_vld_o === 1'b1) begin
      r_idx <= resp_idx_o;
      r_busy <= resp_busy_o;
      r_err <= resp_err_o;
      nresp <= nresp + 1;
    end
    if (erase_go_o === 1'b1) n_erase <= n_erase + 1;
  end
  //////////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [127:0] got, input logic [127:0] exp);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic cmd(input logic [5:0] idx, input logic [31:0] arg, input logic bad = 1'b0);
    int k;
    k = nresp;
    host.send(idx, arg, bad);
    repeat (20) @(negedge clk_i);
    chk(nresp - k, bad ? 0 : 1);
    if (!bad) chk(r_idx, idx);
  endtask
  task automatic pulse(input logic done);
    @(negedge clk_i);
    if (done) op_done = 1'b1;
    else blk_done = 1'b1;
    @(negedge clk_i);
    op_done = 1'b0;
    blk_done = 1'b0;
    repeat (3) @(negedge clk_i);
  endtask
  function automatic logic [127:0] csd_exp(input logic [127:0] o, r, m);
    return (o & ~m) | (r & m);
  endfunction
  function automatic logic [31:0] tag_out(input int k);
    logic [31:0] t[6];
    t = '{sec_first_o, sec_last_o, untag_sec_o, grp_first_o, grp_last_o, untag_grp_o};
    return t[k];
  endfunction
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  initial begin
    #400000;
    mismatches++;
    close_out();
  end
  //////////////////////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(18949));
    dflt = 32'h1 << ($urandom % 10);
    repeat (2) @(negedge clk_i);
    rst_n_i = 1'b1;
    chk({dat0_o, dat0_oe_n_o, resp_vld_o, erase_go_o}, 4'b1100);
    a = ($urandom % 64) * phys;
    cmd(`CCD_IDX_RD_ONE, a);
    chk({xfer_o, resp_err_o, xfer_addr_o, blk_len_o}, {CCD_XF_RD, 1'b0, a, dflt});
    pulse(0);
    chk(xfer_o, CCD_XF_NONE);
    $display("test read_one done");
    len = 32'h2 << ($urandom % 8);
    cmd(`CCD_IDX_BLKLEN, len);
    chk({r_busy, blk_len_o}, {1'b0, len});
    for (int k = 0; k < 4; k++) begin
      rflag = k[0];
      wflag = k[0];
      cmd(k[1] ? `CCD_IDX_WR_ONE : `CCD_IDX_RD_ONE, phys - 1);
      chk({r_err, xfer_o}, {~k[0], k[1] ? CCD_XF_WR : CCD_XF_RD});
      pulse(0);
      pulse(1);
    end
    $display("test misalign done");
    for (int k = 0; k < 2; k++) begin
      cnt = 16'h2 + 16'($urandom % 3);
      cmd(`CCD_IDX_BLKCNT, {16'h0000, cnt});
      chk({r_err, blk_cnt_o}, {1'b0, cnt});
      cmd(k ? `CCD_IDX_WR_MUL : `CCD_IDX_RD_MUL, 32'h0);
      chk(blk_cnt_act_o, 1'b1);
      repeat (cnt - 1) pulse(0);
      chk(xfer_o, k ? CCD_XF_WR : CCD_XF_RD);
      pulse(0);
      chk({xfer_o, blk_cnt_act_o}, {CCD_XF_NONE, 1'b0});
      cmd(k ? `CCD_IDX_WR_MUL : `CCD_IDX_RD_MUL, phys);
      repeat (5) pulse(0);
      chk({xfer_o, blk_cnt_act_o}, {k ? CCD_XF_WR : CCD_XF_RD, 1'b0});
      cmd(`CCD_IDX_STOP, 32'h0);
      pulse(1);
      chk(xfer_o, CCD_XF_NONE);
    end
    cmd(`CCD_IDX_BLKCNT, 32'h0001_0001);
    chk(r_err, 1'b1);
    a = $urandom;
    cmd(`CCD_IDX_STREAM_WR, a);
    chk({xfer_o, xfer_addr_o}, {CCD_XF_STREAM, a});
    cmd(`CCD_IDX_STOP, 32'h0);
    pulse(1);
    chk(xfer_o, CCD_XF_NONE);
    $display("test multi done");
    for (int k = 0; k < 2; k++) begin
      rxb = {$urandom, $urandom, $urandom, $urandom};
      mask = {$urandom, $urandom, $urandom, $urandom};
      if (k == 0) idm = rxb;
      cmd(`CCD_IDX_PROG_ID, 32'h0);
      chk(r_err, k[0]);
      pulse(0);
      pulse(1);
      chk({card_identity_locked_o, card_identity_register_o}, {1'b1, idm});
      cmd(`CCD_IDX_PROG_CSD, 32'h0);
      pulse(0);
      pulse(1);
      csd_m = csd_exp(csd_m, rxb, mask);
      chk(card_specific_data_register_o, csd_m);
    end
    $display("test program done");
    for (int k = 0; k < 6; k++) begin
      v = $urandom;
      cmd(`CCD_IDX_SEC_START + 6'(k), v);
      chk(tag_out(k), v);
    end
    chk({sel_sec_o, sel_grp_o}, 2'b11);
    n = n_erase;
    cmd(`CCD_IDX_ERASE, 32'h0);
    chk({r_busy, dat0_oe_n_o, dat0_o, n_erase - n == 1}, 4'b1001);
    pulse(1);
    chk({dat0_oe_n_o, sel_sec_o, sel_grp_o}, 3'b100);
    $display("test erase done");
    g = $urandom % 31;
    for (int k = 0; k < 2; k++) begin
      cmd(`CCD_IDX_PROT_SET, (g + k) * gsz + ($urandom % gsz));
      chk({r_busy, dat0_oe_n_o}, 2'b10);
      pulse(1);
    end
    chk(wp_bits_o, 32'h3 << g);
    for (int k = 0; k < 2; k++) begin
      cmd(`CCD_IDX_PROT_STAT, (g + k) * gsz);
      chk({xfer_o, wp_payload_o}, {CCD_XF_WP_STAT, 30'h0, ~k[0], 1'b1, 16'h0});
      pulse(0);
    end
    cmd(`CCD_IDX_PROT_CLR, g * gsz);
    chk({r_busy, dat0_oe_n_o}, 2'b10);
    pulse(1);
    chk(wp_bits_o, 32'h2 << g);
    $display("test protect done");
    cmd(`CCD_IDX_LOCK, 32'h0);
    chk(xfer_o, CCD_XF_LOCK);
    pulse(0);
    chk(dat0_oe_n_o, 1'b0);
    pulse(1);
    chk(dat0_oe_n_o, 1'b1);
    // A frame sent while the enable is low must leave no trace.
    n = nresp;
    ce_i = 1'b0;
    host.send(`CCD_IDX_BLKLEN, 32'h3, 1'b0);
    ce_i = 1'b1;
    repeat (20) @(negedge clk_i);
    chk({nresp - n, blk_len_o}, {32'h0, len});
    cmd(`CCD_IDX_BLKLEN, 32'h4, 1'b1);
    chk(blk_len_o, len);
    $display("test lock and framing done");
    close_out();
  end
endmodule
